// file: bench/pps_far_model.sv
// Far-side model: program store, keys and TTL event line.
`timescale 1ns/1ps
module pps_far_model
    import pps_pkg::*;
(
    input wire logic pclk,
    input wire logic [6:0] phase_addr,
    output logic [11:0] phase_word,
    output pps_pins_t pins
);
    logic [11:0] rom [0:127];
    initial begin
        pins = '0;
        pins.event_in = 1'b1;
        pins.prog_in = 1'b1;
        foreach (rom[i]) rom[i] = 12'h000;
    end
    assign phase_word = rom[phase_addr];
    // Low for several cycles, then back high.
    task automatic edge_low();
        @(posedge pclk);
        pins.event_in <= 1'b0;
        repeat (8) @(posedge pclk);
        pins.event_in <= 1'b1;
    endtask
    task automatic stop_press();
        @(posedge pclk);
        pins.stop_key <= 1'b1;
        repeat (8) @(posedge pclk);
        pins.stop_key <= 1'b0;
    endtask
endmodule

// file: bench/pps_seq_sva.sv
// Port-level checks on the pump program flow sequencer.
`timescale 1ns/1ps
module pps_seq_sva
    import pps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] phase_word,
    input wire logic step_start,
    input wire logic prog_out,
    input wire logic clear_total
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic bad;
    logic ro;
    assign bad = paddr > PPS_REG_TRIG || paddr[1:0] != 2'h0;
    assign ro = paddr == PPS_REG_STATUS || paddr == PPS_REG_PHASE ||
        paddr == PPS_REG_TRAP;
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (pready && bad |-> pslverr)
        else $error("unmapped access not refused");
    a_ro_write_err: assert property (pready && pwrite && ro |-> pslverr)
        else $error("write to read-only register not refused");
    a_mapped_read_ok: assert property (pready && !pwrite && !bad &&
        paddr != PPS_REG_CMD |-> !pslverr)
        else $error("mapped read refused");
    a_clear_one_shot: assert property (clear_total |=> !clear_total)
        else $error("clear_total longer than one cycle");
    a_step_one_shot: assert property (step_start |=> !step_start)
        else $error("step_start longer than one cycle");
    a_out_from_phase: assert property ($changed(prog_out) |->
        ($past(phase_word[11:8]) == PPS_OP_SET_OUTPUT &&
        prog_out == $past(phase_word[0])) ||
        ($past(phase_word[11:8], 2) == PPS_OP_SET_OUTPUT &&
        prog_out == $past(phase_word[0], 2)))
        else $error("prog_out changed without a set-output phase");
    c_clear: cover property (clear_total);
    c_out_rise: cover property ($rose(prog_out));
    c_refused: cover property (pslverr);
endmodule
bind pps_sequencer pps_seq_sva chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .phase_word(phase_word),
    .step_start(step_start), .prog_out(prog_out),
    .clear_total(clear_total));

// file: bench/tb_top.sv
// Self-checking bench for the pump program flow sequencer.
`timescale 1ns/1ps
module tb_top;
    import pps_pkg::*;
    typedef struct packed {
        logic [95:0] w;
        logic [3:0] n, act;
        logic pin;
        logic [3:0] pumps;
        logic out, clr;
        logic [7:0] trig;
    } pps_case_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, pumping, step_start, buzzer, prog_out;
    logic clear_total;
    pps_pins_t pins;
    logic [11:0] phase_word;
    logic [6:0] last_phase = 7'h08;
    logic [6:0] phase_addr;
    logic [7:0] trig_mode, display;
    logic [31:0] rnd = 32'h2F76;
    int error_cnt = 0;
    int num_checks = 0;
    int clr_cnt = 0;
    int pumps;
    // Actions: 1 event edge, 2 serial event, 3 redirected stop,
    // 4 start after zero pause, 5 plain stop, 6 other key then start.
    pps_case_t cases [0:14] = '{
        '{96'h300_000_503_100_000_000_000_000, 4, 0, 1, 3, 0, 0, 0},
        '{96'h300_300_000_502_503_100_000_000, 6, 0, 1, 6, 0, 0, 0},
        '{96'h300_300_300_000_502_502_502_100, 8, 0, 1, 8, 0, 0, 0},
        '{96'h000_502_000_000_000_000_000_000, 2, 0, 1, 2, 0, 0, 0},
        '{96'h904_000_100_D01_100_000_000_000, 5, 1, 1, 1, 1, 0, 0},
        '{96'h804_000_100_D01_100_000_000_000, 5, 1, 1, 1, 1, 0, 0},
        '{96'h804_000_100_D01_100_000_000_000, 5, 2, 1, 1, 1, 0, 0},
        '{96'h904_000_100_D01_100_000_000_000, 5, 3, 1, 1, 1, 0, 0},
        '{96'h905_A00_000_100_D01_000_000_000, 5, 2, 1, 1, 0, 0, 0},
        '{96'h000_D01_100_000_000_000_000_000, 3, 3, 1, 1, 1, 0, 0},
        '{96'hD01_B00_C05_706_D00_100_000_000, 6, 0, 0, 0, 1, 1, 5},
        '{96'hD01_B00_C05_706_D00_100_000_000, 6, 0, 1, 0, 0, 1, 5},
        '{96'h680_D01_100_000_000_000_000_000, 3, 4, 1, 0, 1, 0, 0},
        '{96'h680_D01_100_000_000_000_000_000, 3, 6, 1, 0, 0, 0, 0},
        '{96'h000_300_D01_000_D00_400_000_000, 6, 5, 1, 3, 1, 0, 0}};

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (clear_total === 1'b1) clr_cnt++;

    pps_far_model far_u (.pclk(pclk), .phase_addr(phase_addr),
        .phase_word(phase_word), .pins(pins));
    pps_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .phase_word(phase_word),
        .last_phase(last_phase), .phase_addr(phase_addr),
        .pumping(pumping), .step_start(step_start), .buzzer(buzzer),
        .prog_out(prog_out), .clear_total(clear_total),
        .trig_mode(trig_mode), .display(display));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        if (pready !== 1'b1)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input pps_case_t c);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++)
            far_u.rom[i + 1] = c.w[95 - 12 * i -: 12];
        last_phase <= {3'h0, c.n};
        far_u.pins.prog_in <= c.pin;
        apb(1'b1, PPS_REG_CTRL, c.act == 3 ? 32'h4 : c.act >= 4 ? 32'h2 : 0);
        clr_cnt = 0;
        pumps = 0;
        apb(1'b1, PPS_REG_CMD, 32'h1);
        for (int n = 0; n < 600; n++) begin
            @(posedge pclk);
            if (n == 30 && (c.act == 4 || c.act == 6)) begin
                chk("buzzer", buzzer, 1);
                if (c.act == 6)
                    apb(1'b1, PPS_REG_CMD, 32'h4);
                apb(1'b1, PPS_REG_CMD, 32'h1);
            end
            if (step_start === 1'b1) begin
                pumps++;
                if (pumps == 1 && c.act == 1)
                    far_u.edge_low();
                else if (pumps == 1 && c.act == 2)
                    apb(1'b1, PPS_REG_CMD, 32'h8);
                else if ((pumps == 1 && c.act == 3) ||
                    (pumps == 3 && c.act == 5))
                    far_u.stop_press();
                else
                    apb(1'b1, PPS_REG_CMD, 32'h10);
            end
        end
        chk("pumps", pumps, c.pumps);
        chk("prog_out", prog_out, c.out);
        chk("clears", clr_cnt, c.clr);
        chk("trig_mode", trig_mode, c.trig);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, PPS_REG_TRIG, rnd);
            apb(1'b0, PPS_REG_TRIG, 32'h0);
            chk("trig_rd", rd[7:0], rnd[7:0]);
            chk("trig_pin", trig_mode, rnd[7:0]);
        end
        apb(1'b1, PPS_REG_STATUS, rnd);
        chk("ro_err", err, 1);
        apb(1'b0, 12'h0F0, 32'h0);
        chk("bad_err", err, 1);
        foreach (cases[k]) run(cases[k]);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
endmodule

// file: design/pps_pkg.sv
// Package for the pump program flow sequencer: opcodes, offsets, timing.
package pps_pkg;

    localparam int PPS_CLK_HZ = 20000000;
    localparam int PPS_TENTH_MS = 100;
    localparam int PPS_TENTH_CYC = PPS_CLK_HZ / 1000 * PPS_TENTH_MS;
    localparam int PPS_LOW_HOLD_MS = 200;
    localparam int PPS_LOW_HOLD_CYC = PPS_CLK_HZ / 1000 * PPS_LOW_HOLD_MS;
    localparam int PPS_MAX_PAUSE_S = 99;
    localparam logic [7:0] PPS_TENTHS_SHOWN = 8'h01;
    localparam int PPS_LOOP_DEPTH = 3;
    localparam logic [6:0] PPS_FIRST_PHASE = 7'h01;

    // Register byte offsets.
    localparam logic [11:0] PPS_REG_CTRL = 12'h000;
    localparam logic [11:0] PPS_REG_CMD = 12'h004;
    localparam logic [11:0] PPS_REG_STATUS = 12'h008;
    localparam logic [11:0] PPS_REG_PHASE = 12'h00C;
    localparam logic [11:0] PPS_REG_TRAP = 12'h010;
    localparam logic [11:0] PPS_REG_TRIG = 12'h014;

    // CTRL bits.
    localparam int PPS_CTRL_RUN = 0;
    localparam int PPS_CTRL_ALARM = 1;
    localparam int PPS_CTRL_KEY_REDIR = 2;
    localparam int PPS_CTRL_TRIG_REDIR = 3;
    // CMD bits, write one to pulse.
    localparam int PPS_CMD_START = 0;
    localparam int PPS_CMD_STOP = 1;
    localparam int PPS_CMD_OTHER_KEY = 2;
    localparam int PPS_CMD_RUN_EVENT = 3;
    localparam int PPS_CMD_STEP_DONE = 4;

    localparam logic [7:0] PPS_DEF_TRIG_MODE = 8'h00;

    // Phase word: opcode in [11:8], argument in [7:0].
    typedef enum logic [3:0] {
        PPS_OP_PUMP = 4'h0,
        PPS_OP_STOP = 4'h1,
        PPS_OP_JUMP = 4'h2,
        PPS_OP_LOOP_START = 4'h3,
        PPS_OP_LOOP_END_CONT = 4'h4,
        PPS_OP_LOOP_END_CNT = 4'h5,
        PPS_OP_PAUSE = 4'h6,
        PPS_OP_IF_JUMP = 4'h7,
        PPS_OP_TRAP_EDGE_LEVEL = 4'h8,
        PPS_OP_TRAP_EITHER = 4'h9,
        PPS_OP_TRAP_CANCEL = 4'hA,
        PPS_OP_CLEAR_TOTAL = 4'hB,
        PPS_OP_TRIG_OVERRIDE = 4'hC,
        PPS_OP_SET_OUTPUT = 4'hD
    } pps_op_t;

    typedef struct packed {
        logic [6:0] start;
        logic [7:0] left;
    } pps_loop_t;

    typedef struct packed {
        logic start_key;
        logic stop_key;
        logic other_key;
        logic trig_start;
        logic trig_stop;
        logic event_in;
        logic prog_in;
    } pps_pins_t;

endpackage

// file: design/pps_sequencer.sv
// Program flow sequencer for a stored pumping program with APB registers.
// What this block does
// - Continuous loop end branches to latest unpaired loop start, else phase 1.
// - Unpaired loop end pairs with latest unpaired start, else phase 1.
// - Each paired loop end counts one iteration and returns to start.
// - Counted loop end continues after itself when done and releases pairing.
// - Loops nest up to three layers.
// - Nonzero pause waits that many seconds, showing a falling count.
// - Pause with decimal point lasts tenths of seconds, display shows 01.
// - Zero pause with point waits for a start trigger, then next phase.
// - The serial other-key command during that wait stops and resets the program; the other_key pin is not read.
// - With alarms on, buzzer sounds throughout the start-trigger wait.
// - Conditional jump goes to target when program input is low.
// - Event trap arms single shot, active until fired, redefined, cancelled or reset.
// - Edge-level trap fires on falling edge or serial command, or at setup if the input has already been low 200 ms.
// - A firing trap interrupts the program, jumps to target and disarms.
// - A new trap setup replaces any armed trap.
// - Either-edge trap fires on any edge of event input or serial command.
// - Trap cancel disarms any trap.
// - Clear total resets infused and withdrawn totals to zero.
// - Trigger override sets trigger mode; program start uses the default.
// - With redirection, stop fires the trap, or advances if none armed.
// - Redirection clears after firing and leaves trigger mode alone.
// - Set output drives the output pin low for 0, high for 1.
// - Running past the highest phase stops the program.
`timescale 1ns/1ps
module pps_sequencer
    import pps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pps_pins_t pins,
    input wire logic [11:0] phase_word,
    input wire logic [6:0] last_phase,
    output logic [6:0] phase_addr,
    output logic pumping,
    output logic step_start,
    output logic buzzer,
    output logic prog_out,
    output logic clear_total,
    output logic [7:0] trig_mode,
    output logic [7:0] display
);

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_EXEC, S_STEP, S_PAUSE, S_WAIT_START
    } pps_state_t;

    typedef struct packed {
        pps_state_t st;
        logic [6:0] pc;
        pps_loop_t [PPS_LOOP_DEPTH-1:0] stk;
        logic [1:0] depth;
        logic trap_armed;
        logic trap_either;
        logic [6:0] trap_target;
        logic [22:0] tick;
        logic [7:0] count;
        logic tenths;
        logic [22:0] low_cnt;
        logic ev_q;
        logic [3:0] key_q;
        logic [3:0] sub;
        logic [3:0] ctrl;
        logic [7:0] trig_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic step_start;
        logic pumping;
        logic buzzer;
        logic prog_out;
        logic clear_total;
        logic [7:0] display;
    } pps_regs_t;

    pps_regs_t r;
    pps_regs_t next_r;

    function automatic logic [6:0] pps_next_pc(input logic [6:0] pc);
        return pc + 7'h01;
    endfunction

    logic wr_acc;
    logic rd_acc;
    logic [31:0] rd_word;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_other;
    logic cmd_run_ev;
    logic cmd_step_done;
    logic start_trig;
    logic stop_trig;
    logic ev_fall;
    logic ev_rise;
    logic stop_key_hit;
    logic trig_stop_hit;
    logic trap_fire;
    pps_op_t op;
    logic [7:0] arg;

    assign wr_acc = psel & penable & pwrite & ~r.pready;
    assign rd_acc = psel & penable & ~pwrite & ~r.pready;
    assign cmd_start = wr_acc && paddr == PPS_REG_CMD && pwdata[PPS_CMD_START];
    assign cmd_stop = wr_acc && paddr == PPS_REG_CMD && pwdata[PPS_CMD_STOP];
    assign cmd_other = wr_acc && paddr == PPS_REG_CMD
        && pwdata[PPS_CMD_OTHER_KEY];
    assign cmd_run_ev = wr_acc && paddr == PPS_REG_CMD
        && pwdata[PPS_CMD_RUN_EVENT];
    assign cmd_step_done = wr_acc && paddr == PPS_REG_CMD
        && pwdata[PPS_CMD_STEP_DONE];
    // Keys and triggers act once per press, not for as long as they are held.
    assign stop_key_hit = pins.stop_key & ~r.key_q[2];
    assign trig_stop_hit = pins.trig_stop & ~r.key_q[0];
    assign start_trig = cmd_start | (pins.start_key & ~r.key_q[3])
        | (pins.trig_start & ~r.key_q[1]);
    assign stop_trig = cmd_stop | stop_key_hit | trig_stop_hit;
    assign ev_fall = r.ev_q & ~pins.event_in;
    assign ev_rise = ~r.ev_q & pins.event_in;
    assign trap_fire = r.trap_armed && (cmd_run_ev || ev_fall
        || (r.trap_either && ev_rise));
    assign op = pps_op_t'(phase_word[11:8]);
    assign arg = phase_word[7:0];

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            PPS_REG_CTRL: rd_word = {28'h0, r.ctrl};
            PPS_REG_STATUS: rd_word = {16'h0, r.display, 1'b0,
                r.trap_armed, r.pumping, r.buzzer, r.prog_out, r.st};
            PPS_REG_PHASE: rd_word = {23'h0, r.depth, r.pc};
            PPS_REG_TRAP: rd_word = {23'h0, r.trap_either, 1'b0,
                r.trap_target};
            PPS_REG_TRIG: rd_word = {24'h0, r.trig_mode};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.pready = psel & penable & ~r.pready;
        next_r.pslverr = 1'b0;
        next_r.step_start = 1'b0;
        next_r.clear_total = 1'b0;
        next_r.ev_q = pins.event_in;
        next_r.key_q = {pins.start_key, pins.stop_key, pins.trig_start,
            pins.trig_stop};
        if (rd_acc) begin
            next_r.prdata = rd_word;
            next_r.pslverr = !(paddr == PPS_REG_CTRL
                || paddr == PPS_REG_STATUS || paddr == PPS_REG_PHASE
                || paddr == PPS_REG_TRAP || paddr == PPS_REG_TRIG);
        end
        if (wr_acc) begin
            if (paddr == PPS_REG_CTRL) begin
                next_r.ctrl = pwdata[3:0];
            end else if (paddr == PPS_REG_TRIG) begin
                next_r.trig_mode = pwdata[7:0];
            end else if (paddr != PPS_REG_CMD) begin
                next_r.pslverr = 1'b1;
            end
        end
        if (pins.event_in) begin
            next_r.low_cnt = 23'h0;
        end else if (r.low_cnt != 23'(PPS_LOW_HOLD_CYC)) begin
            next_r.low_cnt = r.low_cnt + 23'h1;
        end
        case (r.st)
            S_IDLE: begin
                next_r.pumping = 1'b0;
                if (start_trig) begin
                    next_r.trig_mode = PPS_DEF_TRIG_MODE;
                    next_r.pc = PPS_FIRST_PHASE;
                    next_r.depth = 2'd0;
                    next_r.trap_armed = 1'b0;
                    next_r.st = S_FETCH;
                end
            end
            S_FETCH: begin
                if (r.pc > last_phase || r.pc == 7'h00) begin
                    next_r.st = S_IDLE;
                end else begin
                    next_r.st = S_EXEC;
                end
            end
            S_EXEC: begin
                next_r.pc = pps_next_pc(r.pc);
                next_r.st = S_FETCH;
                case (op)
                    PPS_OP_PUMP: begin
                        next_r.pc = r.pc;
                        next_r.pumping = 1'b1;
                        next_r.step_start = 1'b1;
                        next_r.st = S_STEP;
                    end
                    PPS_OP_STOP: next_r.st = S_IDLE;
                    PPS_OP_JUMP: next_r.pc = arg[6:0];
                    PPS_OP_LOOP_START: begin
                        if (r.depth != 2'(PPS_LOOP_DEPTH)) begin
                            // The scope begins after the mark, so a return
                            // never pushes the same loop a second time.
                            next_r.stk[r.depth].start = pps_next_pc(r.pc);
                            next_r.stk[r.depth].left = 8'h00;
                            next_r.depth = r.depth + 2'd1;
                        end
                    end
                    PPS_OP_LOOP_END_CONT: begin
                        if (r.depth == 2'd0) begin
                            next_r.pc = PPS_FIRST_PHASE;
                        end else begin
                            next_r.pc = {1'b0,
                                r.stk[r.depth - 2'd1].start[5:0]};
                        end
                    end
                    PPS_OP_LOOP_END_CNT: begin
                        if (r.depth == 2'd0) begin
                            // Implied start at phase 1 needs its own entry.
                            if (arg > 8'h01) begin
                                next_r.stk[0].start = {1'b1,
                                    PPS_FIRST_PHASE[5:0]};
                                next_r.stk[0].left = arg - 8'h02;
                                next_r.depth = 2'd1;
                                next_r.pc = PPS_FIRST_PHASE;
                            end
                        end else if (r.stk[r.depth - 2'd1].left == 8'h00
                            && r.stk[r.depth - 2'd1].start[6] == 1'b0
                            && arg > 8'h01
                            && r.stk[r.depth - 2'd1].left != 8'hFF) begin
                            // Fresh pairing: first iteration just finished.
                            next_r.stk[r.depth - 2'd1].left = arg - 8'h02;
                            next_r.stk[r.depth - 2'd1].start[6] = 1'b1;
                            next_r.pc = r.stk[r.depth - 2'd1].start;
                        end else if (r.stk[r.depth - 2'd1].start[6]
                            && r.stk[r.depth - 2'd1].left != 8'h00) begin
                            next_r.stk[r.depth - 2'd1].left =
                                r.stk[r.depth - 2'd1].left - 8'h01;
                            next_r.pc = {1'b0,
                                r.stk[r.depth - 2'd1].start[5:0]};
                        end else begin
                            next_r.depth = r.depth - 2'd1;
                        end
                    end
                    PPS_OP_PAUSE: begin
                        next_r.pc = r.pc;
                        next_r.tenths = arg[7];
                        next_r.tick = 23'h0;
                        next_r.sub = 4'h0;
                        if (arg[6:0] == 7'h00 && arg[7]) begin
                            next_r.st = S_WAIT_START;
                        end else if (arg[6:0] == 7'h00) begin
                            next_r.pc = pps_next_pc(r.pc);
                        end else begin
                            next_r.count = {1'b0, arg[6:0]};
                            next_r.st = S_PAUSE;
                        end
                        next_r.pumping = 1'b0;
                    end
                    PPS_OP_IF_JUMP: begin
                        if (!pins.prog_in) begin
                            next_r.pc = arg[6:0];
                        end
                    end
                    PPS_OP_TRAP_EDGE_LEVEL, PPS_OP_TRAP_EITHER: begin
                        next_r.trap_armed = 1'b1;
                        next_r.trap_target = arg[6:0];
                        next_r.trap_either = (op == PPS_OP_TRAP_EITHER);
                        if (op == PPS_OP_TRAP_EDGE_LEVEL
                            && r.low_cnt == 23'(PPS_LOW_HOLD_CYC)) begin
                            next_r.trap_armed = 1'b0;
                            next_r.pc = arg[6:0];
                        end
                    end
                    PPS_OP_TRAP_CANCEL: next_r.trap_armed = 1'b0;
                    PPS_OP_CLEAR_TOTAL: next_r.clear_total = 1'b1;
                    PPS_OP_TRIG_OVERRIDE: next_r.trig_mode = arg;
                    PPS_OP_SET_OUTPUT: next_r.prog_out = arg[0];
                    default: next_r.st = S_FETCH;
                endcase
            end
            S_STEP: begin
                if (cmd_step_done) begin
                    next_r.pc = pps_next_pc(r.pc);
                    next_r.st = S_FETCH;
                end
            end
            S_PAUSE: begin
                next_r.display = r.tenths ? PPS_TENTHS_SHOWN : r.count;
                if (r.tick == 23'(PPS_TENTH_CYC - 1)) begin
                    next_r.tick = 23'h0;
                    next_r.sub = r.sub + 4'h1;
                    // Whole-second pauses step the count every ten tenths.
                    if (r.tenths || r.sub == 4'h9) begin
                        next_r.sub = 4'h0;
                        next_r.count = r.count - 8'h01;
                        if (r.count == 8'h01) begin
                            next_r.pc = pps_next_pc(r.pc);
                            next_r.st = S_FETCH;
                        end
                    end
                end else begin
                    next_r.tick = r.tick + 23'h1;
                end
            end
            S_WAIT_START: begin
                next_r.buzzer = r.ctrl[PPS_CTRL_ALARM];
                if (cmd_other) begin
                    next_r.st = S_IDLE;
                    next_r.buzzer = 1'b0;
                end else if (start_trig) begin
                    next_r.pc = pps_next_pc(r.pc);
                    next_r.st = S_FETCH;
                    next_r.buzzer = 1'b0;
                end
            end
            default: next_r.st = S_IDLE;
        endcase
        if (r.st != S_IDLE && stop_trig) begin
            if ((cmd_stop | stop_key_hit) && r.ctrl[PPS_CTRL_KEY_REDIR]
                || (cmd_stop | trig_stop_hit)
                && r.ctrl[PPS_CTRL_TRIG_REDIR]) begin
                if (r.trap_armed) begin
                    next_r.trap_armed = 1'b0;
                    next_r.pc = r.trap_target;
                    next_r.ctrl[PPS_CTRL_KEY_REDIR] = 1'b0;
                    next_r.ctrl[PPS_CTRL_TRIG_REDIR] = 1'b0;
                end else begin
                    next_r.pc = pps_next_pc(r.pc);
                end
                next_r.buzzer = 1'b0;
                next_r.st = S_FETCH;
            end else begin
                next_r.st = S_IDLE;
                next_r.buzzer = 1'b0;
            end
        end else if (r.st != S_IDLE && trap_fire) begin
            next_r.trap_armed = 1'b0;
            next_r.pc = r.trap_target;
            next_r.buzzer = 1'b0;
            next_r.st = S_FETCH;
        end
        if (next_r.st == S_IDLE) begin
            next_r.pumping = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= S_IDLE;
            r.pc <= PPS_FIRST_PHASE;
            r.ev_q <= 1'b1;
            r.trig_mode <= PPS_DEF_TRIG_MODE;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign phase_addr = r.pc;
    assign pumping = r.pumping;
    assign step_start = r.step_start;
    assign buzzer = r.buzzer;
    assign prog_out = r.prog_out;
    assign clear_total = r.clear_total;
    assign trig_mode = r.trig_mode;
    assign display = r.display;

endmodule
